// File: fpurf_consts.svh
// constants for the float register file and control-register bank
`ifndef FPURF_CONSTS_SVH
`define FPURF_CONSTS_SVH
`define FPURF_CR_IMPL 5'h00
`define FPURF_CR_CCV 5'h19
`define FPURF_CR_EXV 5'h1A
`define FPURF_CR_ENV 5'h1C
`define FPURF_CR_CS 5'h1F
`define FPURF_IMPL_CAPS 32'h01730000
`define FPURF_REVISION 8'h00
`define FPURF_CS_WMASK 32'hFFE3FFFF
`define FPURF_EXV_MASK 32'h0003F07C
`define FPURF_ENV_MASK 32'h00000F87
`define FPURF_CS_FS_BIT 24
`define FPURF_CS_CC0_BIT 23
`define FPURF_CS_CCHI_LSB 25
`define FPURF_ENV_FS_BIT 2
`define FPURF_NREGS 32
`endif

// File: fpurf_pkg.sv
// types for the float register file and control-register bank
package fpurf_pkg;
    typedef enum logic [2:0] {
        FMT_UNINTERP, FMT_UNKNOWN, FMT_SINGLE, FMT_DOUBLE, FMT_WORD, FMT_LONG
    } fpurf_fmt_type;

    typedef enum logic [2:0] {
        OP_NONE, OP_LOAD, OP_STORE, OP_COMPUTE, OP_MOVE_HI_TO, OP_MOVE_HI_FROM
    } fpurf_op_type;

    // one pipeline request to the register file
    typedef struct packed {
        fpurf_op_type op;
        logic wide;
        fpurf_fmt_type fmt;
        logic [4:0] srcReg;
        logic [4:0] dstReg;
        logic [63:0] data;
    } fpurf_req_type;

    // one control-register access
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] num;
        logic [31:0] data;
    } fpurf_cr_type;
endpackage

// File: fpurf_ctrl_regs.sv
// control-register bank with the views onto the control/status word
`timescale 1ns/100ps
`default_nettype none
`include "fpurf_consts.svh"
module fpurf_ctrl_regs (
    input wire logic clock,
    input wire logic rstn,
    input wire fpurf_pkg::fpurf_cr_type cr,
    input wire logic [7:0] procIdent,
    output logic [31:0] rdata,
    output logic rsvd
);
    logic [31:0] ctrlStatus;
    logic [31:0] next_ctrlStatus;
    logic [7:0] ccBits;

    assign ccBits = {ctrlStatus[31:25], ctrlStatus[`FPURF_CS_CC0_BIT]};

    // merge a write through any view into the one underlying word
    always_comb begin
        next_ctrlStatus = ctrlStatus;
        if (cr.valid && cr.write) begin
            case (cr.num)
                `FPURF_CR_CS: begin
                    next_ctrlStatus = cr.data & `FPURF_CS_WMASK;
                end
                `FPURF_CR_CCV: begin
                    next_ctrlStatus[31:25] = cr.data[7:1];
                    next_ctrlStatus[`FPURF_CS_CC0_BIT] = cr.data[0];
                end
                `FPURF_CR_EXV: begin
                    next_ctrlStatus = (ctrlStatus & ~`FPURF_EXV_MASK) |
                        (cr.data & `FPURF_EXV_MASK);
                end
                `FPURF_CR_ENV: begin
                    next_ctrlStatus[11:7] = cr.data[11:7];
                    next_ctrlStatus[1:0] = cr.data[1:0];
                    next_ctrlStatus[`FPURF_CS_FS_BIT] =
                        cr.data[`FPURF_ENV_FS_BIT];
                end
                default: begin
                    next_ctrlStatus = ctrlStatus;
                end
            endcase
        end
    end

    // reset to zero so reads are predictable before software sets it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrlStatus <= 32'h00000000;
        end else begin
            ctrlStatus <= next_ctrlStatus;
        end
    end

    // read mux; reserved fields are never stored so they read zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h00000000;
            rsvd <= 1'b0;
        end else begin
            rsvd <= 1'b0;
            if (cr.valid && !cr.write) begin
                case (cr.num)
                    `FPURF_CR_IMPL: begin
                        rdata <= `FPURF_IMPL_CAPS |
                            {16'h0000, procIdent, `FPURF_REVISION};
                    end
                    `FPURF_CR_CCV: begin
                        rdata <= {24'h000000, ccBits};
                    end
                    `FPURF_CR_EXV: begin
                        rdata <= ctrlStatus & `FPURF_EXV_MASK;
                    end
                    `FPURF_CR_ENV: begin
                        rdata <= {20'h00000, ctrlStatus[11:7], 4'h0,
                            ctrlStatus[`FPURF_CS_FS_BIT],
                            ctrlStatus[1:0]};
                    end
                    `FPURF_CR_CS: begin
                        rdata <= ctrlStatus;
                    end
                    default: begin
                        rdata <= 32'h00000000;
                        rsvd <= 1'b1;
                    end
                endcase
            end else if (cr.valid && cr.write) begin
                rsvd <= !(cr.num == `FPURF_CR_IMPL ||
                    cr.num == `FPURF_CR_CCV || cr.num == `FPURF_CR_EXV ||
                    cr.num == `FPURF_CR_ENV || cr.num == `FPURF_CR_CS);
            end
        end
    end

    a_ccv_mirror: assert property (@(posedge clock) disable iff (!rstn)
        (cr.valid && cr.write && cr.num == `FPURF_CR_CCV) |=>
        ccBits == $past(cr.data[7:0]))
        else $error("condition view write not mirrored");
    a_impl_value: assert property (@(posedge clock) disable iff (!rstn)
        (cr.valid && !cr.write && cr.num == `FPURF_CR_IMPL) |=>
        rdata[31:16] == 16'h0173 && rdata[15:8] == $past(procIdent))
        else $error("implementation word wrong");
    a_cs_reserved: assert property (@(posedge clock) disable iff (!rstn)
        ctrlStatus[20:18] == 3'h0)
        else $error("reserved status bits set");
endmodule
`default_nettype wire

// File: fpurf_format_track.sv
// per-register format tag tracking
`timescale 1ns/100ps
`default_nettype none
`include "fpurf_consts.svh"
module fpurf_format_track (
    input wire logic clock,
    input wire logic rstn,
    input wire logic accept,
    input wire fpurf_pkg::fpurf_req_type req,
    output fpurf_pkg::fpurf_fmt_type srcFmt
);
    fpurf_pkg::fpurf_fmt_type tags [`FPURF_NREGS];

    assign srcFmt = tags[req.srcReg];

    // tags change only on accepted requests; stores never touch them
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `FPURF_NREGS; i++) begin
                tags[i] <= fpurf_pkg::FMT_UNINTERP;
            end
        end else if (accept) begin
            case (req.op)
                fpurf_pkg::OP_LOAD, fpurf_pkg::OP_MOVE_HI_TO: begin
                    tags[req.dstReg] <= fpurf_pkg::FMT_UNINTERP;
                end
                fpurf_pkg::OP_COMPUTE: begin
                    if (tags[req.srcReg] == fpurf_pkg::FMT_UNINTERP) begin
                        tags[req.srcReg] <= req.fmt;
                    end else if (tags[req.srcReg] != req.fmt) begin
                        tags[req.srcReg] <= fpurf_pkg::FMT_UNKNOWN;
                    end
                    // a bad source poisons the result; dst write comes last
                    if (tags[req.srcReg] == fpurf_pkg::FMT_UNKNOWN ||
                        (tags[req.srcReg] != fpurf_pkg::FMT_UNINTERP &&
                         tags[req.srcReg] != req.fmt)) begin
                        tags[req.dstReg] <= fpurf_pkg::FMT_UNKNOWN;
                    end else begin
                        tags[req.dstReg] <= req.fmt;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    a_load_uninterp: assert property (@(posedge clock) disable iff (!rstn)
        (accept && req.op == fpurf_pkg::OP_LOAD) |=>
        tags[$past(req.dstReg)] == fpurf_pkg::FMT_UNINTERP)
        else $error("load left a format tag");
    a_store_keeps: assert property (@(posedge clock) disable iff (!rstn)
        (accept && req.op == fpurf_pkg::OP_STORE) |=>
        tags[$past(req.srcReg)] == $past(srcFmt))
        else $error("store changed a format tag");
endmodule
`default_nettype wire

// File: fpurf_top.sv
// float register file with format tracking and the control-register bank
`timescale 1ns/100ps
`default_nettype none
`include "fpurf_consts.svh"
// Functional notes
// - width bit set: 32 registers of 64 bits, any format anywhere
// - width bit clear: 32 narrow registers, doubles in even-odd pairs
// - narrow model: double op naming odd register raises reserved fault
// - narrow model: high-half moves on odd register raise reserved fault
// - single and word use low half; double and long use all 64 bits
// - load leaves destination uninterpreted
// - compute marks destination with result format; high-half move in leaves it uninterpreted
// - uninterpreted source read takes the format of the reader
// - mismatched source makes source and result unknown
// - store keeps format and outputs the raw bits
// - stores read back exactly what the matching load wrote
// - five 32-bit control registers at numbers 0, 25, 26, 28, 31
// - views 25, 26, 28 update the one control/status word
// - reserved fields never set by hardware and read zero
// - read-only fields ignore writes
// - read-only fields take their preset values from power-up
// - writable fields show hardware state and start at a known value
// - implementation word reports capability bits 24,22,21,20,17,16 set
// - implementation bits 19 and 18 read zero
// - bits 15:8 mirror the system processor identification field
// - bits 7:0 hold revision; bits 31:25 and 23 read zero
// - condition view shows all eight condition bits contiguously
// - condition view bits 31:8 read zero
module fpurf_top (
    input wire logic clock,
    input wire logic rstn,
    input wire logic registerWidthSelect,
    input wire logic [7:0] systemProcessorIdent,
    input wire fpurf_pkg::fpurf_req_type req,
    input wire fpurf_pkg::fpurf_cr_type cr,
    output logic [63:0] readData,
    output logic readValid,
    output logic reservedFault,
    output logic [31:0] crReadData,
    output logic crReservedFault,
    output logic wideRegisterModel
);
    // ****************************************************************
    // storage and decode
    // ****************************************************************
    logic [31:0] lowHalf [`FPURF_NREGS];
    logic [31:0] highHalf [`FPURF_NREGS];
    logic badAccess;
    logic accept;
    logic isWideFmt;

    // true for formats that fill a whole 64-bit register
    function automatic logic fmt_is_wide(input fpurf_pkg::fpurf_fmt_type f);
        fmt_is_wide = (f == fpurf_pkg::FMT_DOUBLE) ||
            (f == fpurf_pkg::FMT_LONG);
    endfunction

    // odd register check, used by several operations in narrow mode
    function automatic logic odd_reg(input logic [4:0] r);
        odd_reg = r[0];
    endfunction

    assign isWideFmt = (req.op == fpurf_pkg::OP_COMPUTE) ?
        fmt_is_wide(req.fmt) : req.wide;

    // narrow-model restrictions; the mode bit is core logic, same clock
    always_comb begin
        badAccess = 1'b0;
        if (!registerWidthSelect) begin
            case (req.op)
                fpurf_pkg::OP_MOVE_HI_TO, fpurf_pkg::OP_MOVE_HI_FROM: begin
                    badAccess = odd_reg(req.dstReg) ||
                        odd_reg(req.srcReg);
                end
                fpurf_pkg::OP_NONE: begin
                    badAccess = 1'b0;
                end
                default: begin
                    badAccess = isWideFmt && (odd_reg(req.dstReg) ||
                        odd_reg(req.srcReg));
                end
            endcase
        end
    end

    assign accept = (req.op != fpurf_pkg::OP_NONE) && !badAccess;

    // ****************************************************************
    // data storage
    // ****************************************************************
    // in narrow mode the high half of an even register lives in the odd
    // neighbour; wide mode keeps it in the second array highHalf, so mode
    // changes move where the high half is found; the cost is a mux on the pair index
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `FPURF_NREGS; i++) begin
                lowHalf[i] <= 32'h00000000;
                highHalf[i] <= 32'h00000000;
            end
        end else if (accept) begin
            case (req.op)
                fpurf_pkg::OP_LOAD, fpurf_pkg::OP_COMPUTE: begin
                    lowHalf[req.dstReg] <= req.data[31:0];
                    if (isWideFmt) begin
                        if (registerWidthSelect) begin
                            highHalf[req.dstReg] <= req.data[63:32];
                        end else begin
                            lowHalf[req.dstReg | 5'h01] <=
                                req.data[63:32];
                        end
                    end
                end
                fpurf_pkg::OP_MOVE_HI_TO: begin
                    if (registerWidthSelect) begin
                        highHalf[req.dstReg] <= req.data[31:0];
                    end else begin
                        lowHalf[req.dstReg | 5'h01] <= req.data[31:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    // raw bits go out whatever the tag; unknown values are just the bits
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            readData <= 64'h0000000000000000;
            readValid <= 1'b0;
        end else begin
            readValid <= accept && (req.op == fpurf_pkg::OP_STORE ||
                req.op == fpurf_pkg::OP_MOVE_HI_FROM);
            if (accept && req.op == fpurf_pkg::OP_STORE) begin
                if (!req.wide) begin
                    readData <= {32'h00000000, lowHalf[req.srcReg]};
                end else if (registerWidthSelect) begin
                    readData <= {highHalf[req.srcReg],
                        lowHalf[req.srcReg]};
                end else begin
                    readData <= {lowHalf[req.srcReg | 5'h01],
                        lowHalf[req.srcReg]};
                end
            end else if (accept && req.op == fpurf_pkg::OP_MOVE_HI_FROM) begin
                readData <= {32'h00000000, registerWidthSelect ?
                    highHalf[req.srcReg] :
                    lowHalf[req.srcReg | 5'h01]};
            end
        end
    end

    // fault pulse and mode mirror
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reservedFault <= 1'b0;
            wideRegisterModel <= 1'b0;
        end else begin
            reservedFault <= badAccess;
            wideRegisterModel <= registerWidthSelect;
        end
    end

    // ****************************************************************
    // submodules
    // ****************************************************************
    fpurf_format_track u_track (
        .clock(clock),
        .rstn(rstn),
        .accept(accept),
        .req(req),
        .srcFmt()
    );

    // preset identity values come from constants and the systemProcessorIdent input, never stored state
    fpurf_ctrl_regs u_cregs (
        .clock(clock),
        .rstn(rstn),
        .cr(cr),
        .procIdent(systemProcessorIdent),
        .rdata(crReadData),
        .rsvd(crReservedFault)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_wide_load;
        accept && req.op == fpurf_pkg::OP_LOAD && req.wide;
    endsequence

    sequence s_wide_store_same;
        accept && req.op == fpurf_pkg::OP_STORE && req.wide &&
        req.srcReg == $past(req.dstReg) && !$past(registerWidthSelect) ==
        !registerWidthSelect;
    endsequence

    a_odd_double: assert property (@(posedge clock) disable iff (!rstn)
        (!registerWidthSelect && req.op == fpurf_pkg::OP_COMPUTE &&
         fmt_is_wide(req.fmt) &&
         (odd_reg(req.dstReg) || odd_reg(req.srcReg))) |=>
        reservedFault)
        else $error("odd double not faulted");
    a_odd_high: assert property (@(posedge clock) disable iff (!rstn)
        (!registerWidthSelect && req.op == fpurf_pkg::OP_MOVE_HI_TO &&
         odd_reg(req.dstReg)) |=> reservedFault && !readValid)
        else $error("odd high move not faulted");
    a_wide_roundtrip: assert property (@(posedge clock) disable iff (!rstn)
        s_wide_load ##1 s_wide_store_same |=>
        readData == $past(req.data, 2))
        else $error("wide round trip mismatch");
    a_rsvd_number: assert property (@(posedge clock) disable iff (!rstn)
        (cr.valid && cr.num == 5'h05) |=> crReservedFault)
        else $error("reserved number accepted");
    a_impl_zeros: assert property (@(posedge clock) disable iff (!rstn)
        (cr.valid && !cr.write && cr.num == 5'h00) |=>
        crReadData[31:25] == 7'h00 && !crReadData[23] &&
        crReadData[19:18] == 2'h0)
        else $error("implementation zero bits set");
endmodule
`default_nettype wire

// File: fpurf_pipe_model.sv
// pipeline-side driver model for the float register file
`timescale 1ns/100ps
`default_nettype none
module fpurf_pipe_model (
    input wire logic clock,
    output fpurf_pkg::fpurf_req_type req,
    output fpurf_pkg::fpurf_cr_type cr
);
    // idle from time zero, so nothing is offered before reset ends
    initial begin
        req = '0;
        cr = '0;
    end

    // two requests on consecutive edges, then withdrawn
    // sources are also read back in another width, as one half of a written pair
    task automatic send_two(input fpurf_pkg::fpurf_req_type a,
                            input fpurf_pkg::fpurf_req_type b);
        @(posedge clock);
        req <= a;
        @(posedge clock);
        req <= b;
        @(posedge clock);
        req.op <= fpurf_pkg::OP_NONE;
    endtask

    // two control accesses by 5-bit number, back to back
    // the status word is read right after reset, before any write to it
    // reserved bits get ones only where a test probes masking
    task automatic cr_two(input fpurf_pkg::fpurf_cr_type a,
                          input fpurf_pkg::fpurf_cr_type b);
        @(posedge clock);
        cr <= a;
        @(posedge clock);
        cr <= b;
        @(posedge clock);
        cr.valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: fpu_register_file_and_control_regs_tb_top.sv
// self-checking bench for the float register file and control bank
`timescale 1ns/100ps
`default_nettype none
module fpu_register_file_and_control_regs_tb_top;
    // ************************************************************
    // stimulus tables
    // ************************************************************
    localparam fpurf_pkg::fpurf_op_type LD = fpurf_pkg::OP_LOAD;
    localparam fpurf_pkg::fpurf_op_type ST = fpurf_pkg::OP_STORE;
    localparam fpurf_pkg::fpurf_op_type CP = fpurf_pkg::OP_COMPUTE;
    localparam fpurf_pkg::fpurf_op_type HT = fpurf_pkg::OP_MOVE_HI_TO;
    localparam fpurf_pkg::fpurf_op_type HF = fpurf_pkg::OP_MOVE_HI_FROM;
    localparam logic [63:0] DW = 64'h1122334455667788;
    localparam logic [63:0] SW = 64'h00000000CAFEF00D;
    localparam logic [63:0] HW = 64'h000000005A5A5A5A;
    localparam logic [7:0] IDENT = 8'h3C; // arbitrary identification value
    typedef struct packed {
        logic mode;
        fpurf_pkg::fpurf_op_type op;
        logic wide;
        logic dbl;
        logic [4:0] src;
        logic [4:0] dst;
        logic [63:0] data;
        logic vld;
        logic flt;
        logic full;
        logic [63:0] ex;
    } fpurf_rfrow_type;
    typedef struct packed {
        logic [4:0] wn;
        logic [31:0] wd;
        logic [4:0] rn;
        logic [31:0] ex;
        logic flt;
    } fpurf_crrow_type;
    // mode op wide dbl src dst data | valid fault full expected
    fpurf_rfrow_type rfRows [16] = '{
        '{1'h1, LD, 1'h1, 1'h0, 5'h00, 5'h03, DW, 1'h0, 1'h0, 1'h1, 64'h0},
        '{1'h1, ST, 1'h1, 1'h0, 5'h03, 5'h00, 64'h0, 1'h1, 1'h0, 1'h1, DW},
        '{1'h1, LD, 1'h0, 1'h0, 5'h00, 5'h05, SW, 1'h0, 1'h0, 1'h0, 64'h0},
        '{1'h1, ST, 1'h0, 1'h0, 5'h05, 5'h00, 64'h0, 1'h1, 1'h0, 1'h0, SW},
        '{1'h0, LD, 1'h1, 1'h0, 5'h00, 5'h03, DW, 1'h0, 1'h1, 1'h0, 64'h0},
        '{1'h0, LD, 1'h1, 1'h0, 5'h00, 5'h02, DW, 1'h0, 1'h0, 1'h0, 64'h0},
        '{1'h0, ST, 1'h1, 1'h0, 5'h02, 5'h00, 64'h0, 1'h1, 1'h0, 1'h1, DW},
        '{1'h0, ST, 1'h0, 1'h0, 5'h03, 5'h00, 64'h0, 1'h1, 1'h0, 1'h0,
          64'h11223344},
        '{1'h0, HF, 1'h0, 1'h0, 5'h03, 5'h00, 64'h0, 1'h0, 1'h1, 1'h0, 64'h0},
        '{1'h0, HF, 1'h0, 1'h0, 5'h02, 5'h00, 64'h0, 1'h1, 1'h0, 1'h0,
          64'h11223344},
        '{1'h0, HT, 1'h0, 1'h0, 5'h00, 5'h03, HW, 1'h0, 1'h1, 1'h0, 64'h0},
        '{1'h0, ST, 1'h0, 1'h0, 5'h03, 5'h00, 64'h0, 1'h1, 1'h0, 1'h0,
          64'h11223344},
        '{1'h0, HT, 1'h0, 1'h0, 5'h00, 5'h02, HW, 1'h0, 1'h0, 1'h0, 64'h0},
        '{1'h0, ST, 1'h1, 1'h0, 5'h02, 5'h00, 64'h0, 1'h1, 1'h0, 1'h1,
          64'h5A5A5A5A55667788},
        '{1'h0, CP, 1'h0, 1'h1, 5'h01, 5'h04, 64'h0, 1'h0, 1'h1, 1'h0, 64'h0},
        '{1'h0, ST, 1'h1, 1'h0, 5'h03, 5'h00, 64'h0, 1'h0, 1'h1, 1'h0, 64'h0}
    };
    // write number/data, then read number: expected word, fault
    fpurf_crrow_type crRows [11] = '{
        '{5'h1F, 32'hFFFFFFFF, 5'h1F, 32'hFFE3FFFF, 1'h0},
        '{5'h19, 32'h000000A5, 5'h1F, 32'hA4800000, 1'h0},
        '{5'h19, 32'hFFFFFFFF, 5'h19, 32'h000000FF, 1'h0},
        '{5'h1A, 32'hFFFFFFFF, 5'h1F, 32'h0003F07C, 1'h0},
        '{5'h1A, 32'hFFFFFFFF, 5'h1A, 32'h0003F07C, 1'h0},
        '{5'h1C, 32'hFFFFFFFF, 5'h1C, 32'h00000F87, 1'h0},
        '{5'h1C, 32'hFFFFFFFF, 5'h1F, 32'h01000F83, 1'h0},
        '{5'h1F, 32'hFFFFFFFF, 5'h1A, 32'h0003F07C, 1'h0},
        '{5'h00, 32'hFFFFFFFF, 5'h00, 32'h01733C00, 1'h0},
        '{5'h05, 32'hFFFFFFFF, 5'h05, 32'h00000000, 1'h1},
        '{5'h05, 32'hFFFFFFFF, 5'h1F, 32'h00000000, 1'h0}
    };

    logic clock;
    logic rstn;
    logic registerWidthSelect;
    logic [7:0] systemProcessorIdent;
    fpurf_pkg::fpurf_req_type req;
    fpurf_pkg::fpurf_cr_type cr;
    fpurf_pkg::fpurf_req_type idle = '0;
    fpurf_pkg::fpurf_cr_type crIdle = '0;
    logic [63:0] readData;
    logic readValid;
    logic reservedFault;
    logic [31:0] crReadData;
    logic crReservedFault;
    logic wideRegisterModel;
    int err_count = 0;
    int checked = 0;

    fpurf_top u_dut (
        .clock(clock), .rstn(rstn),
        .registerWidthSelect(registerWidthSelect),
        .systemProcessorIdent(systemProcessorIdent),
        .req(req), .cr(cr), .readData(readData), .readValid(readValid),
        .reservedFault(reservedFault), .crReadData(crReadData),
        .crReservedFault(crReservedFault),
        .wideRegisterModel(wideRegisterModel)
    );
    fpurf_pipe_model u_pipe (.clock(clock), .req(req), .cr(cr));

    // ************************************************************
    // checking helpers
    // ************************************************************
    task automatic cmp_vec(input string what, input logic [63:0] exp,
                           input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp,
                           input logic got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    // every output quiet and every read word cleared
    task automatic check_idle;
        cmp_bit("readValid", 1'b0, readValid);
        cmp_bit("reservedFault", 1'b0, reservedFault);
        cmp_bit("crReservedFault", 1'b0, crReservedFault);
        cmp_bit("wideRegisterModel", 1'b0, wideRegisterModel);
        cmp_vec("readData", 64'h0, readData);
        cmp_vec("crReadData", 64'h0, {32'h0, crReadData});
    endtask

    // read one control word on its own; result stands after return
    task automatic cr_read(input logic [4:0] num, input logic [31:0] exp);
        u_pipe.cr_two(crIdle, '{1'b1, 1'b0, num, 32'h0});
        #1;
        cmp_vec("crReadData", {32'h0, exp}, {32'h0, crReadData});
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // hang guard: a run that outlives this is counted as a mismatch
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        $display("[FAIL] run length expected end seen hang");
        finish_test();
    end

    initial begin
        rstn = 1'b0;
        registerWidthSelect = 1'b0;
        systemProcessorIdent = IDENT;
        repeat (20) @(posedge clock);
        #1;
        check_idle();
        @(posedge clock);
        rstn <= 1'b1;
        cr_read(5'h00, 32'h01733C00);
        cr_read(5'h1F, 32'h0);
        $display("test reset done, mismatches %0d", err_count);
        // register file rows, each request alone
        for (int i = 0; i < 16; i++) begin
            if (registerWidthSelect !== rfRows[i].mode) begin
                @(posedge clock);
                registerWidthSelect <= rfRows[i].mode;
                repeat (2) @(posedge clock);
            end
            u_pipe.send_two(idle, '{rfRows[i].op, rfRows[i].wide,
                rfRows[i].dbl ? fpurf_pkg::FMT_DOUBLE : fpurf_pkg::FMT_UNINTERP,
                rfRows[i].src, rfRows[i].dst, rfRows[i].data});
            #1;
            cmp_bit("wideRegisterModel", rfRows[i].mode,
                    wideRegisterModel);
            cmp_bit("readValid", rfRows[i].vld, readValid);
            cmp_bit("reservedFault", rfRows[i].flt, reservedFault);
            if (rfRows[i].vld && rfRows[i].full) begin
                cmp_vec("readData", rfRows[i].ex, readData);
            end else if (rfRows[i].vld) begin
                cmp_vec("readData low", {32'h0, rfRows[i].ex[31:0]},
                        {32'h0, readData[31:0]});
            end
        end
        $display("test register rows done, mismatches %0d", err_count);
        // control rows: clear, then write and read on adjacent edges
        for (int i = 0; i < 11; i++) begin
            u_pipe.cr_two(crIdle, '{1'b1, 1'b1, 5'h1F, 32'h0});
            u_pipe.cr_two('{1'b1, 1'b1, crRows[i].wn, crRows[i].wd},
                          '{1'b1, 1'b0, crRows[i].rn, 32'h0});
            #1;
            cmp_bit("crReservedFault", crRows[i].flt,
                    crReservedFault);
            if (!crRows[i].flt) begin
                cmp_vec("crReadData", {32'h0, crRows[i].ex},
                        {32'h0, crReadData});
            end
        end
        $display("test control rows done, mismatches %0d", err_count);
        // load then store on consecutive edges
        u_pipe.send_two('{LD, 1'b1, fpurf_pkg::FMT_UNINTERP, 5'h00, 5'h06,
                          64'h0F1E2D3C4B5A6978},
                        '{ST, 1'b1, fpurf_pkg::FMT_UNINTERP, 5'h06, 5'h00,
                          64'h0});
        #1;
        cmp_bit("readValid", 1'b1, readValid);
        cmp_vec("readData", 64'h0F1E2D3C4B5A6978, readData);
        $display("test back to back done, mismatches %0d", err_count);
        // reset in mid-run after the status word was filled
        registerWidthSelect <= 1'b1;
        u_pipe.cr_two(crIdle, '{1'b1, 1'b1, 5'h1F, 32'hFE63FFFF});
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check_idle();
        @(posedge clock);
        rstn <= 1'b1;
        cr_read(5'h1F, 32'h0);
        $display("test second reset done, mismatches %0d", err_count);
        finish_test();
    end
endmodule
`default_nettype wire
